/* src/srs_top.sv */
// Startup reset sequencer: reset merge, clock request, sleep and boot.
`timescale 1ns/1ps
// Notes on behaviour
// R1: Reset held while either reset asserted.
// R2: Power-on reset lasts typically 3 ms.
// R3: Both reset paths run same sequence. External reset after boot skips detection and reuses the old verdict.
// R4: Clock request asserted 120 us after release.
// R5: Sleep at least 4.2 ms after release.
// R6: Host clocks stable by end of sleep.
// R7: Crystal assumed when no TCXO present.
// R8: Missing low-power clock selects internal one.
// R9: Host holds clear-to-send high 50 ms.
// R10: Boot after sleep and clock selection.
module srs_top
  import srs_pkg::*;
#(
  parameter int unsigned POR_CYC = POR_TYP_CYC,
  parameter int unsigned CLKREQ_CYC = CLKREQ_DLY_CYC,
  parameter int unsigned SLEEP_CYC = SLEEP_MIN_CYC,
  parameter int unsigned CTS_CYC = CTS_HOLD_CYC,
  parameter int unsigned LPC_WIN = LPC_WIN_CYC,
  parameter bit HAS_CLKREQ = 1'b1
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ext_reset_n_i,
  input wire logic tcxo_present_i,
  input wire logic low_power_clock_input_i,
  input wire logic host_clear_to_send_in_i,
  output logic chip_reset_n_o,
  output logic clk_req_o,
  output logic sleep_o,
  output logic crystal_osc_en_o,
  output logic low_power_osc_en_o,
  output logic use_ext_lpc_o,
  output logic boot_o,
  output logic autobaud_o
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [1:0] rst_s_reg, lpc_s_reg, cts_s_reg, tcxo_s_reg;

  // Two flops per pin; only the second flop is read by logic.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s_reg <= 2'h0;
      lpc_s_reg <= 2'h0;
      cts_s_reg <= 2'h3;
      tcxo_s_reg <= 2'h0;
    end else begin
      rst_s_reg <= {rst_s_reg[0], ext_reset_n_i};
      lpc_s_reg <= {lpc_s_reg[0], low_power_clock_input_i};
      cts_s_reg <= {cts_s_reg[0], host_clear_to_send_in_i};
      tcxo_s_reg <= {tcxo_s_reg[0], tcxo_present_i};
    end
  end

  // ==========================================================================
  // Power-on reset timer and reset merge
  // ==========================================================================
  logic [CNT_W-1:0] por_reg, por_next;
  logic por_act;
  logic glob_rst;

  // Power-on timer starts at power-up, modelled by reset_n_i release.
  always_comb begin
    por_next = por_reg;
    if (por_reg != '0) begin
      por_next = por_reg - CNT_W'(1); // R2
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      por_reg <= CNT_W'(POR_CYC);
    end else begin
      por_reg <= por_next;
    end
  end

  assign por_act = (por_reg != '0);
  // Chip stays in reset until the later of the two is released.
  assign glob_rst = por_act || !rst_s_reg[1]; // R1

  // ==========================================================================
  // Post-reset sequencer
  // ==========================================================================
  srs_state_type st_reg, st_next;
  logic [CNT_W-1:0] tmr_reg, tmr_next;
  logic [CNT_W-1:0] cts_reg, cts_next;
  logic creq_reg, creq_next;
  logic boot_reg, boot_next;
  logic abd_reg, abd_next;
  logic xtal_reg, xtal_next;
  logic det_start;
  logic det_done;
  logic det_pres;

  // One sequence serves both reset paths; it restarts on any new reset, but detection restarts only on reset_n_i.
  always_comb begin
    st_next = st_reg;
    tmr_next = tmr_reg;
    cts_next = cts_reg;
    creq_next = creq_reg;
    boot_next = boot_reg;
    abd_next = abd_reg;
    xtal_next = xtal_reg;
    if (glob_rst) begin
      st_next = ST_RESET; // R3
      tmr_next = '0;
      cts_next = '0;
      creq_next = 1'b0;
      boot_next = 1'b0;
      abd_next = 1'b0;
    end else begin
      if (st_reg != ST_RESET && tmr_reg != {CNT_W{1'b1}}) begin
        tmr_next = tmr_reg + CNT_W'(1);
      end
      if (cts_reg != CNT_W'(CTS_CYC) && st_reg != ST_RESET) begin
        cts_next = cts_reg + CNT_W'(1);
        if (!cts_s_reg[1] && !boot_reg) begin
          abd_next = 1'b1; // R9
        end
      end
      case (st_reg)
        ST_RESET: begin
          st_next = ST_SLEEP;
          tmr_next = CNT_W'(1);
          cts_next = CNT_W'(1);
          xtal_next = !tcxo_s_reg[1]; // R7
        end
        ST_SLEEP: begin
          if (HAS_CLKREQ && tmr_reg >= CNT_W'(CLKREQ_CYC)) begin
            creq_next = 1'b1; // R4
          end
          if (tmr_reg >= CNT_W'(SLEEP_CYC)) begin
            st_next = ST_RESOLVE; // R5 R6
          end
        end
        ST_RESOLVE: begin
          if (det_done) begin
            st_next = ST_BOOT; // R10
            boot_next = 1'b1;
          end
        end
        ST_BOOT: begin
          boot_next = 1'b1;
        end
        default: begin
          st_next = ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= ST_RESET;
      tmr_reg <= '0;
      cts_reg <= '0;
      creq_reg <= 1'b0;
      boot_reg <= 1'b0;
      abd_reg <= 1'b0;
      xtal_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      cts_reg <= cts_next;
      creq_reg <= creq_next;
      boot_reg <= boot_next;
      abd_reg <= abd_next;
      xtal_reg <= xtal_next;
    end
  end

  // Detection runs during sleep, after the external clock had time to start.
  assign det_start = (st_reg == ST_RESOLVE);

  // ==========================================================================
  // Low-power clock detection
  // ==========================================================================
  logic det_rst_n;
  assign det_rst_n = reset_n_i;

  srs_clk_detect #(
    .WIN_CYC(LPC_WIN),
    .MIN_EDGES(LPC_MIN_EDGES)
  ) u_detect (
    .mclk_i(mclk_i),
    .reset_n_i(det_rst_n),
    .start_i(det_start),
    .clk_sync_i(lpc_s_reg[1]),
    .done_o(det_done),
    .present_o(det_pres)
  );

  // ==========================================================================
  // Outputs
  // ==========================================================================
  logic chip_rst_n_reg, chip_rst_n_next;
  logic use_ext_reg, use_ext_next;

  // Next values of the reset and clock selection outputs.
  always_comb begin
    chip_rst_n_next = !glob_rst; // R1
    use_ext_next = use_ext_reg;
    if (det_done) begin
      use_ext_next = det_pres; // R8
    end
  end

  // Registered reset and clock selection outputs.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chip_rst_n_reg <= 1'b0;
      use_ext_reg <= 1'b0;
    end else begin
      chip_rst_n_reg <= chip_rst_n_next;
      use_ext_reg <= use_ext_next;
    end
  end

  assign chip_reset_n_o = chip_rst_n_reg;
  assign clk_req_o = creq_reg;
  assign sleep_o = (st_reg == ST_SLEEP) || (st_reg == ST_RESOLVE);
  assign crystal_osc_en_o = xtal_reg;
  assign low_power_osc_en_o = det_done && !use_ext_reg; // R8
  assign use_ext_lpc_o = use_ext_reg;
  assign boot_o = boot_reg;
  assign autobaud_o = abd_reg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_released;
    $fell(glob_rst);
  endsequence

  a_reset_merge: assert property ( // R1
    @(posedge mclk_i) disable iff (!reset_n_i)
    glob_rst |=> !chip_rst_n_reg)
    else $error("Chip reset not held during reset.");

  a_por_length: assert property ( // R2
    @(posedge mclk_i) disable iff (!reset_n_i)
    $fell(por_act) |-> $past(por_reg) == CNT_W'(1))
    else $error("Power-on reset ended early.");

  a_same_path: assert property ( // R3
    @(posedge mclk_i) disable iff (!reset_n_i)
    s_released |=> st_reg == ST_SLEEP)
    else $error("Sequence did not start after release.");

  a_clkreq_time: assert property ( // R4
    @(posedge mclk_i) disable iff (!reset_n_i)
    $rose(creq_reg) |-> tmr_reg == CNT_W'(CLKREQ_CYC) + CNT_W'(1))
    else $error("Clock request at wrong time.");

  a_sleep_min: assert property ( // R5
    @(posedge mclk_i) disable iff (!reset_n_i)
    $fell(sleep_o) && !glob_rst |-> tmr_reg > CNT_W'(SLEEP_CYC))
    else $error("Sleep ended too early.");

  a_boot_order: assert property ( // R10
    @(posedge mclk_i) disable iff (!reset_n_i)
    $rose(boot_reg) |-> det_done && tmr_reg > CNT_W'(SLEEP_CYC))
    else $error("Boot before sleep and clock selection.");

  // At boot the selection must already follow the detector's verdict.
  a_lpo_select: assert property ( // R8
    @(posedge mclk_i) disable iff (!reset_n_i)
    boot_reg |-> det_done && (use_ext_reg == det_pres) &&
      (low_power_osc_en_o != use_ext_reg))
    else $error("Low-power clock selection inconsistent.");

  a_boot_no_reset: assert property ( // R3
    @(posedge mclk_i) disable iff (!reset_n_i)
    boot_reg |-> chip_rst_n_reg || glob_rst)
    else $error("Boot while chip in reset.");

endmodule

/* pkg/srs_pkg.sv */
// Package holding timing constants and states of the startup reset sequencer.
package srs_pkg;

  // ==========================================================================
  // Clock rate
  // ==========================================================================
  localparam int unsigned CLK_HZ = 40000000;

  // ==========================================================================
  // Times in their own units, as printed
  // ==========================================================================
  localparam int unsigned POR_TYP_US = 3000;
  localparam int unsigned POR_MIN_US = 1500;
  localparam int unsigned CLKREQ_DLY_US = 120;
  localparam int unsigned SLEEP_MIN_US = 4200;
  localparam int unsigned CTS_HOLD_MS = 50;

  // ==========================================================================
  // Derived cycle counts (cycles per unit rounded down)
  // ==========================================================================
  localparam int unsigned POR_TYP_CYC = (POR_TYP_US * (CLK_HZ / 1000000));
  localparam int unsigned CLKREQ_DLY_CYC =
    (CLKREQ_DLY_US * (CLK_HZ / 1000000));
  localparam int unsigned SLEEP_MIN_CYC = (SLEEP_MIN_US * (CLK_HZ / 1000000));
  localparam int unsigned CTS_HOLD_CYC = (CTS_HOLD_MS * (CLK_HZ / 1000));

  // Low-power clock detection window and edge count.
  localparam int unsigned LPC_WIN_CYC = 4096;
  localparam int unsigned LPC_MIN_EDGES = 4;

  // Width of all down counters.
  localparam int unsigned CNT_W = 24;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_RESET,
    ST_SLEEP,
    ST_RESOLVE,
    ST_BOOT
  } srs_state_type;

endpackage

/* src/srs_clk_detect.sv */
// Activity detector for the low-power clock input.
`timescale 1ns/1ps
module srs_clk_detect
  import srs_pkg::*;
#(
  parameter int unsigned WIN_CYC = LPC_WIN_CYC,
  parameter int unsigned MIN_EDGES = LPC_MIN_EDGES
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic clk_sync_i,
  output logic done_o,
  output logic present_o
);

  logic [CNT_W-1:0] win_reg, win_next;
  logic [7:0] edge_reg, edge_next;
  logic prev_reg, prev_next;
  logic run_reg, run_next;
  logic done_reg, done_next;
  logic pres_reg, pres_next;

  // Counts rising edges of the synchronised clock over a fixed window.
  always_comb begin
    win_next = win_reg;
    edge_next = edge_reg;
    prev_next = clk_sync_i;
    run_next = run_reg;
    done_next = done_reg;
    pres_next = pres_reg;
    if (start_i && !run_reg && !done_reg) begin
      run_next = 1'b1;
      win_next = CNT_W'(WIN_CYC);
      edge_next = 8'h00;
    end else if (run_reg) begin
      if (clk_sync_i && !prev_reg && edge_reg != 8'hff) begin
        edge_next = edge_reg + 8'h01;
      end
      if (win_reg == '0) begin
        run_next = 1'b0;
        done_next = 1'b1;
        pres_next = (edge_reg >= 8'(MIN_EDGES));
      end else begin
        win_next = win_reg - CNT_W'(1);
      end
    end
  end

  // Registers the detector state.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      win_reg <= '0;
      edge_reg <= 8'h00;
      prev_reg <= 1'b0;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
      pres_reg <= 1'b0;
    end else begin
      win_reg <= win_next;
      edge_reg <= edge_next;
      prev_reg <= prev_next;
      run_reg <= run_next;
      done_reg <= done_next;
      pres_reg <= pres_next;
    end
  end

  assign done_o = done_reg;
  assign present_o = pres_reg;

  // The verdict never changes once given.
  a_verdict_stable: assert property ( // R8
    @(posedge mclk_i) disable iff (!reset_n_i)
    done_reg |=> done_reg && $stable(pres_reg))
    else $error("Clock detect verdict changed.");

endmodule

/* testbench/srs_host_model.sv */
// Host-side model: external reset, clear-to-send and low-power clock.
`timescale 1ns/1ps
module srs_host_model
  import srs_pkg::*;
#(
  parameter int unsigned CTS_CYC = CTS_HOLD_CYC
) (
  input wire logic mclk_i,
  input wire logic chip_reset_n_i,
  input wire logic hold_ext_i,
  input wire logic run_lpc_i,
  input wire logic cts_early_i,
  output logic ext_reset_n_o,
  output logic lpc_o,
  output logic cts_n_o
);
  logic [3:0] div_reg = 4'h0;
  int unsigned since_reg = 0;
  // ==========================================================================
  // Reset pin and clocks
  // ==========================================================================
  // The host holds the chip in reset for as long as it is asked to.
  assign ext_reset_n_o = ~hold_ext_i;
  // The clock runs from power-up, so it is stable well before sleep ends.
  always @(posedge mclk_i) begin
    div_reg <= div_reg + 4'h1;
  end
  assign lpc_o = run_lpc_i & div_reg[1];
  // ==========================================================================
  // Clear-to-send
  // ==========================================================================
  // Counts cycles since the chip left reset.
  always @(posedge mclk_i) begin
    since_reg <= chip_reset_n_i ? since_reg + 1 : 0;
  end
  // Stays high past the hold time, with margin, unless an early drop is asked.
  assign cts_n_o = cts_early_i ? (since_reg < 10) :
    (since_reg < CTS_CYC + 8);
endmodule

/* testbench/srs_top_bench.sv */
// Self-checking bench for the startup reset sequencer.
`timescale 1ns/1ps
module srs_top_bench;
  import srs_pkg::*;
  localparam int T_POR = 20;
  localparam int T_REQ = 5;
  localparam int T_SLP = 40;
  localparam int T_CTS = 60;
  localparam int T_WIN = 32;
  localparam int T_BOOT = T_SLP + T_WIN;
  typedef struct {
    logic tcxo;
    logic lpc;
    logic cts;
    int ext;
  } srs_row_type;
  srs_row_type rows [4] = '{'{1'b0, 1'b1, 1'b0, 0}, '{1'b1, 1'b0, 1'b1, 0},
    '{1'b0, 1'b0, 1'b0, 60}, '{1'b1, 1'b1, 1'b1, 0}};
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic tcxo_i = 1'b0;
  logic hold_ext = 1'b0;
  logic run_lpc = 1'b0;
  logic cts_early = 1'b0;
  logic ext_n, lpc, cts_n, chip_n, req, slp, xo, low_power_osc, ext_lpc, boot, abd;
  logic req_off;
  int mismatches = 0;
  int num_checks = 0;
  int k;
  // ==========================================================================
  // Clock, design and host model
  // ==========================================================================
  always #12.5 mclk_i = ~mclk_i;
  srs_top #(.POR_CYC(T_POR), .CLKREQ_CYC(T_REQ), .SLEEP_CYC(T_SLP),
    .CTS_CYC(T_CTS), .LPC_WIN(T_WIN), .HAS_CLKREQ(1'b1)) srs_top_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ext_reset_n_i(ext_n),
    .tcxo_present_i(tcxo_i), .low_power_clock_input_i(lpc),
    .host_clear_to_send_in_i(cts_n), .chip_reset_n_o(chip_n),
    .clk_req_o(req), .sleep_o(slp), .crystal_osc_en_o(xo),
    .low_power_osc_en_o(low_power_osc), .use_ext_lpc_o(ext_lpc), .boot_o(boot),
    .autobaud_o(abd));
  srs_host_model #(.CTS_CYC(T_CTS)) srs_host_model_inst (
    .mclk_i(mclk_i), .chip_reset_n_i(chip_n), .hold_ext_i(hold_ext),
    .run_lpc_i(run_lpc), .cts_early_i(cts_early), .ext_reset_n_o(ext_n),
    .lpc_o(lpc), .cts_n_o(cts_n));
  // A variant without the clock-request pin must never raise it.
  srs_top #(.POR_CYC(T_POR), .CLKREQ_CYC(T_REQ), .SLEEP_CYC(T_SLP),
    .CTS_CYC(T_CTS), .LPC_WIN(T_WIN), .HAS_CLKREQ(1'b0)) srs_top_noreq_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ext_reset_n_i(ext_n),
    .tcxo_present_i(tcxo_i), .low_power_clock_input_i(lpc),
    .host_clear_to_send_in_i(cts_n), .chip_reset_n_o(),
    .clk_req_o(req_off), .sleep_o(), .crystal_osc_en_o(),
    .low_power_osc_en_o(), .use_ext_lpc_o(), .boot_o(), .autobaud_o());
  // ==========================================================================
  // Checks and verdict
  // ==========================================================================
  // Reports the verdict and ends the run.
  task automatic give_verdict();
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Compares a count against an inclusive range.
  task automatic chk(input string what, input int lo, input int hi,
                     input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      $display("unexpected %s expected %0d..%0d seen %0d", what, lo, hi, got);
      mismatches++;
    end
  endtask
  // Compares one output bit, so an unknown never matches.
  task automatic chb(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %b seen %b", what, exp, got);
      mismatches++;
    end
  endtask
  // Powers up once with the given host setup and times every step.
  task automatic run_row(input srs_row_type r);
    int n, t_rel, t_req, t_boot, n_slp, n_off, lo;
    reset_n_i = 1'b0;
    tcxo_i = r.tcxo;
    run_lpc = r.lpc;
    cts_early = r.cts;
    hold_ext = (r.ext > 0);
    repeat (5) @(posedge mclk_i);
    #2;
    chb("chip_reset_n_o", 1'b0, chip_n);
    chb("boot_o", 1'b0, boot);
    reset_n_i = 1'b1;
    t_rel = -1;
    t_req = -1;
    t_boot = -1;
    n_slp = 0;
    n_off = 0;
    for (n = 1; n <= 400 && t_boot < 0; n++) begin
      @(posedge mclk_i);
      #2;
      if (n == r.ext) hold_ext = 1'b0;
      if (t_rel < 0 && chip_n === 1'b1) t_rel = n;
      if (t_req < 0 && req === 1'b1) t_req = n;
      if (slp === 1'b1) n_slp++;
      if (req_off !== 1'b0) n_off++;
      if (boot === 1'b1) t_boot = n;
    end
    if (t_boot < 0) begin
      chb("boot_o", 1'b1, boot);
      return;
    end
    lo = (r.ext > T_POR) ? r.ext : T_POR;
    chk("release cycle", lo, lo + 4, t_rel);
    chk("clk_req delay", T_REQ, T_REQ + 2, t_req - t_rel);
    chk("sleep length", T_SLP, T_BOOT + 4, n_slp);
    chk("boot delay", T_BOOT, T_BOOT + 6, t_boot - t_rel);
    chk("clk_req_o without pin", 0, 0, n_off);
    chb("crystal_osc_en_o", ~r.tcxo, xo);
    chb("use_ext_lpc_o", r.lpc, ext_lpc);
    chb("low_power_osc_en_o", ~r.lpc, low_power_osc);
    chb("autobaud_o", r.cts, abd);
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    @(posedge mclk_i);
    #2;
    for (k = 0; k < 4; k++) begin
      run_row(rows[k]);
    end
    // Reasserting the external reset after boot drops chip_reset_n_o, boot_o and clk_req_o within four cycles.
    hold_ext = 1'b1;
    repeat (4) @(posedge mclk_i);
    #2;
    chb("chip_reset_n_o", 1'b0, chip_n);
    chb("boot_o", 1'b0, boot);
    chb("clk_req_o", 1'b0, req);
    hold_ext = 1'b0;
    for (k = 1; k <= 20 && chip_n !== 1'b1; k++) begin
      @(posedge mclk_i);
      #2;
    end
    chk("re-release cycle", 1, 4, k);
    // The same sleep runs again; detection keeps its earlier verdict.
    for (k = 1; k <= 100 && boot !== 1'b1; k++) begin
      @(posedge mclk_i);
      #2;
    end
    chk("re-boot delay", T_SLP, T_SLP + 4, k);
    chb("clk_req_o", 1'b1, req);
    give_verdict();
  end
endmodule
